// file: gpc_controller.sv
// Bus controller command engine with Avalon-MM register access
// Notes on behaviour
// - Interface clear pulses IFC low for 100 us after reinitialising.
// - REN changes only with update enable; parameter 0 drives high, 1 low.
// - Before IFC pulse, go to source mode, standby, ATN high.
// - Reset clears state; all pins released, REN floats.
// - In source mode, status result bit 0 is 1 while any device pulls SRQ low.
// - SRQ is sensed by briefly dropping the EOI/DAV drive control.
// - Standby only releases ATN and floats the data lines.
// - Take control bit 0: 1 asserts ATN now, 0 waits for DAV.
// - Synchronous takeover reports accept timeout if DAV stays low 100 us.
// - Interface message goes with ATN low, ATN stays low afterwards.
// - Acceptor mode is left for source mode before sending a message.
// - DAV already driven low means resume: go straight to NDAC wait.
// - Wait for NRFD high; after 100 us end with ready timeout.
// - NRFD and NDAC both high ends with no listener, else assert DAV.
// - Wait for NDAC high; after 1000 us accept timeout, DAV kept.
// - NDAC high releases DAV and data, result cleared to zero.
// - Result bits: 0 no listener, 1 ready, 2 accept, 7 any error.
// - Every wait ends in a bounded timeout back to the host.
// - Between commands the interface stays in source or acceptor mode, except that reset leaves neither until IFC, take control or acceptor mode.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gpc_controller #(
  parameter int CLK_PER_US = gpc_pkg::CYC_PER_US,
  parameter int IFC_US = gpc_pkg::IFC_PULSE_US,
  parameter int TAKE_US = gpc_pkg::TAKE_DAV_US,
  parameter int READY_US = gpc_pkg::READY_WAIT_US,
  parameter int ACCEPT_US = gpc_pkg::ACCEPT_WAIT_US
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] AV_ADDRESS,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic [31:0] AV_WRITEDATA,
  input wire logic [3:0] AV_BYTEENABLE,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  input wire logic [7:0] DIO_I,
  output logic [7:0] DIO_O,
  output logic [7:0] DIO_OE,
  input wire logic DAV_I,
  output logic DAV_O,
  output logic DAV_OE,
  input wire logic NRFD_I,
  output logic NRFD_O,
  output logic NRFD_OE,
  input wire logic NDAC_I,
  output logic NDAC_O,
  output logic NDAC_OE,
  output logic ATN_O,
  output logic ATN_OE,
  output logic IFC_O,
  output logic IFC_OE,
  output logic REN_O,
  output logic REN_OE,
  input wire logic SRQ_I,
  output logic EOI_DAV_CTL,
  output logic DATA_OUT_DIR
);

  // ********************************************************
  // State and registers
  // ********************************************************
  gpc_pkg::gpc_state_t state_r, state_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] result_r, result_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic atn_o_r, atn_o_nxt, atn_oe_r, atn_oe_nxt;
  logic ifc_o_r, ifc_o_nxt, ifc_oe_r, ifc_oe_nxt;
  logic ren_o_r, ren_o_nxt, ren_oe_r, ren_oe_nxt;
  logic dav_o_r, dav_o_nxt, dav_oe_r, dav_oe_nxt;
  logic nrfd_o_r, nrfd_o_nxt, nrfd_oe_r, nrfd_oe_nxt;
  logic ndac_o_r, ndac_o_nxt, ndac_oe_r, ndac_oe_nxt;
  logic [7:0] dio_o_r, dio_o_nxt;
  logic dio_oe_r, dio_oe_nxt;
  logic acc_mode_r, acc_mode_nxt;
  logic src_en_r, src_en_nxt;
  logic wait_r;
  logic [31:0] rdata_r;

  // ********************************************************
  // Bus slave decode
  // ********************************************************
  wire req = AV_READ | AV_WRITE;
  wire wr_take = AV_WRITE & ~wait_r;
  wire rd_load = AV_READ & wait_r;
  wire sel_cmd = (AV_ADDRESS == gpc_pkg::REG_CMD);
  wire sel_status = (AV_ADDRESS == gpc_pkg::REG_STATUS);
  wire sel_pins = (AV_ADDRESS == gpc_pkg::REG_PINS);
  wire be_ok = (AV_BYTEENABLE[1:0] == 2'b11);
  // Writes while busy are dropped so a running handshake is never disturbed
  wire cmd_go = wr_take & sel_cmd & be_ok & (state_r == gpc_pkg::S_IDLE);
  wire [2:0] go_op = AV_WRITEDATA[gpc_pkg::CMD_OP_LSB +: gpc_pkg::CMD_OP_W];
  wire [7:0] go_prm = AV_WRITEDATA[gpc_pkg::CMD_PRM_LSB +: 8];
  wire [7:0] prm = cmd_r[gpc_pkg::CMD_PRM_LSB +: 8];
  wire dav_driven = dav_oe_r & ~dav_o_r;

  wire [31:0] status_word = {
    21'h000000,
    ~atn_o_r & atn_oe_r,
    acc_mode_r,
    busy_r,
    result_r
  };
  wire [31:0] pins_word = {19'h00000, SRQ_I, NDAC_I, NRFD_I, DAV_I, 1'b0, DIO_I};
  wire [31:0] rd_mux = sel_cmd ? {16'h0000, cmd_r} :
                       sel_status ? status_word :
                       sel_pins ? pins_word : 32'h00000000;

  // ********************************************************
  // Timeout timer and SRQ sensing
  // ********************************************************
  logic tmr_exp;
  logic sense_done;
  logic sense_seen;
  logic sense_ctl;
  wire tmr_clr = (state_r != state_nxt);
  wire sense_start = cmd_go & (go_op == 3'(gpc_pkg::OP_STATUS_IN));
  wire [gpc_pkg::US_W-1:0] lim_ifc = gpc_pkg::US_W'(IFC_US);
  wire [gpc_pkg::US_W-1:0] lim_take = gpc_pkg::US_W'(TAKE_US);
  wire [gpc_pkg::US_W-1:0] lim_ready = gpc_pkg::US_W'(READY_US);
  wire [gpc_pkg::US_W-1:0] lim_accept = gpc_pkg::US_W'(ACCEPT_US);
  wire [gpc_pkg::US_W-1:0] tmr_limit = (state_r == gpc_pkg::S_IFC) ? lim_ifc :
                                       (state_r == gpc_pkg::S_TAKE) ? lim_take :
                                       (state_r == gpc_pkg::S_NRFD) ? lim_ready :
                                       lim_accept;

  gpc_us_timer #(
    .CYC_PER_US(CLK_PER_US),
    .US_W(gpc_pkg::US_W)
  ) u_timer (
    .clk(CLK),
    .rst(RST),
    .clr(tmr_clr),
    .limit_us(tmr_limit),
    .expired(tmr_exp)
  );

  gpc_srq_sense #(
    .SENSE_CYC(gpc_pkg::SENSE_CYC)
  ) u_sense (
    .clk(CLK),
    .rst(RST),
    .start(sense_start),
    .en_i(src_en_nxt),
    .srq_n_i(SRQ_I),
    .ctl_o(sense_ctl),
    .done(sense_done),
    .seen(sense_seen)
  );

  // ********************************************************
  // Command sequencer
  // ********************************************************
  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    result_nxt = result_r;
    cmd_nxt = cmd_r;
    atn_o_nxt = atn_o_r;
    atn_oe_nxt = atn_oe_r;
    ifc_o_nxt = ifc_o_r;
    ifc_oe_nxt = ifc_oe_r;
    ren_o_nxt = ren_o_r;
    ren_oe_nxt = ren_oe_r;
    dav_o_nxt = dav_o_r;
    dav_oe_nxt = dav_oe_r;
    nrfd_o_nxt = nrfd_o_r;
    nrfd_oe_nxt = nrfd_oe_r;
    ndac_o_nxt = ndac_o_r;
    ndac_oe_nxt = ndac_oe_r;
    dio_o_nxt = dio_o_r;
    dio_oe_nxt = dio_oe_r;
    acc_mode_nxt = acc_mode_r;
    src_en_nxt = src_en_r;
    case (state_r)
      gpc_pkg::S_IDLE: begin
        if (cmd_go) begin
          busy_nxt = 1'b1;
          cmd_nxt = AV_WRITEDATA[15:0];
          state_nxt = gpc_pkg::S_FIN;
          result_nxt = 8'h00;
          case (go_op)
            3'(gpc_pkg::OP_CONTROL_OUT): begin
              if (go_prm[gpc_pkg::PRM_REN_UPD]) begin
                ren_oe_nxt = 1'b1;
                ren_o_nxt = ~go_prm[gpc_pkg::PRM_REN];
              end
              if (go_prm[gpc_pkg::PRM_IFC]) begin
                acc_mode_nxt = 1'b0;
                src_en_nxt = 1'b1;
                nrfd_oe_nxt = 1'b0;
                ndac_oe_nxt = 1'b0;
                dav_oe_nxt = 1'b0;
                dav_o_nxt = 1'b1;
                dio_oe_nxt = 1'b0;
                atn_oe_nxt = 1'b1;
                atn_o_nxt = 1'b1;
                ifc_oe_nxt = 1'b1;
                ifc_o_nxt = 1'b0;
                state_nxt = gpc_pkg::S_IFC;
              end
            end
            3'(gpc_pkg::OP_STATUS_IN): begin
              state_nxt = gpc_pkg::S_SRQ;
            end
            3'(gpc_pkg::OP_STANDBY): begin
              atn_oe_nxt = 1'b0;
              atn_o_nxt = 1'b1;
              dio_oe_nxt = 1'b0;
            end
            3'(gpc_pkg::OP_TAKE_CONTROL): begin
              acc_mode_nxt = 1'b0;
              src_en_nxt = 1'b1;
              if (go_prm[gpc_pkg::PRM_ASYNC]) begin
                atn_oe_nxt = 1'b1;
                atn_o_nxt = 1'b0;
              end else begin
                state_nxt = gpc_pkg::S_TAKE;
              end
            end
            3'(gpc_pkg::OP_IFACE_MSG): begin
              if (acc_mode_r) begin
                acc_mode_nxt = 1'b0;
                src_en_nxt = 1'b1;
                nrfd_oe_nxt = 1'b0;
                ndac_oe_nxt = 1'b0;
              end
              atn_oe_nxt = 1'b1;
              atn_o_nxt = 1'b0;
              if (dav_driven) begin
                state_nxt = gpc_pkg::S_NDAC;
              end else begin
                dio_oe_nxt = 1'b1;
                dio_o_nxt = ~go_prm; // Low-true data lines
                state_nxt = gpc_pkg::S_NRFD;
              end
            end
            3'(gpc_pkg::OP_ACCEPT_MODE): begin
              acc_mode_nxt = 1'b1;
              src_en_nxt = 1'b0;
              dio_oe_nxt = 1'b0;
              dav_oe_nxt = 1'b0;
              dav_o_nxt = 1'b1;
              nrfd_oe_nxt = 1'b1;
              nrfd_o_nxt = 1'b0;
              ndac_oe_nxt = 1'b1;
              ndac_o_nxt = 1'b0;
              atn_oe_nxt = 1'b1;
              atn_o_nxt = 1'b1;
            end
            default: begin
              result_nxt = gpc_pkg::gpc_err(gpc_pkg::RES_ANY_ERR);
            end
          endcase
        end
      end
      gpc_pkg::S_IFC: begin
        if (tmr_exp) begin
          ifc_o_nxt = 1'b1;
          state_nxt = gpc_pkg::S_FIN;
        end
      end
      gpc_pkg::S_SRQ: begin
        if (sense_done) begin
          result_nxt = 8'h00;
          result_nxt[gpc_pkg::RES_SRQ] = sense_seen;
          state_nxt = gpc_pkg::S_FIN;
        end
      end
      gpc_pkg::S_TAKE: begin
        if (DAV_I) begin
          atn_oe_nxt = 1'b1;
          atn_o_nxt = 1'b0;
          state_nxt = gpc_pkg::S_FIN;
        end else if (tmr_exp) begin
          result_nxt = gpc_pkg::gpc_err(gpc_pkg::RES_ACCEPT_TO);
          state_nxt = gpc_pkg::S_FIN;
        end
      end
      gpc_pkg::S_NRFD: begin
        if (NRFD_I) begin
          if (NDAC_I) begin
            result_nxt = gpc_pkg::gpc_err(gpc_pkg::RES_NO_LISTENER);
            state_nxt = gpc_pkg::S_FIN;
          end else begin
            dav_oe_nxt = 1'b1;
            dav_o_nxt = 1'b0;
            state_nxt = gpc_pkg::S_NDAC;
          end
        end else if (tmr_exp) begin
          result_nxt = gpc_pkg::gpc_err(gpc_pkg::RES_READY_TO);
          state_nxt = gpc_pkg::S_FIN;
        end
      end
      gpc_pkg::S_NDAC: begin
        if (NDAC_I) begin
          dav_oe_nxt = 1'b1;
          dav_o_nxt = 1'b1;
          dio_oe_nxt = 1'b0;
          result_nxt = 8'h00;
          state_nxt = gpc_pkg::S_FIN;
        end else if (tmr_exp) begin
          // DAV stays low so a reissued message resumes here
          result_nxt = gpc_pkg::gpc_err(gpc_pkg::RES_ACCEPT_TO);
          state_nxt = gpc_pkg::S_FIN;
        end
      end
      gpc_pkg::S_FIN: begin
        busy_nxt = 1'b0;
        state_nxt = gpc_pkg::S_IDLE;
      end
      default: begin
        state_nxt = gpc_pkg::S_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= gpc_pkg::S_IDLE;
      busy_r <= 1'b0;
      result_r <= gpc_pkg::RESULT_RST;
      cmd_r <= 16'h0000;
      {atn_o_r, atn_oe_r, ifc_o_r, ifc_oe_r} <= 4'hA;
      {ren_o_r, ren_oe_r, dav_o_r, dav_oe_r} <= 4'hA;
      {nrfd_o_r, nrfd_oe_r, ndac_o_r, ndac_oe_r} <= 4'hA;
      dio_o_r <= 8'hFF;
      dio_oe_r <= 1'b0;
      acc_mode_r <= 1'b0;
      src_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      result_r <= result_nxt;
      cmd_r <= cmd_nxt;
      {atn_o_r, atn_oe_r, ifc_o_r, ifc_oe_r} <= {atn_o_nxt, atn_oe_nxt, ifc_o_nxt, ifc_oe_nxt};
      {ren_o_r, ren_oe_r, dav_o_r, dav_oe_r} <= {ren_o_nxt, ren_oe_nxt, dav_o_nxt, dav_oe_nxt};
      {nrfd_o_r, nrfd_oe_r} <= {nrfd_o_nxt, nrfd_oe_nxt};
      {ndac_o_r, ndac_oe_r} <= {ndac_o_nxt, ndac_oe_nxt};
      dio_o_r <= dio_o_nxt;
      dio_oe_r <= dio_oe_nxt;
      acc_mode_r <= acc_mode_nxt;
      src_en_r <= src_en_nxt;
    end
  end

  // ********************************************************
  // Bus slave answer
  // ********************************************************
  // One wait cycle per access keeps read data registered
  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (rd_load) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign AV_WAITREQUEST = wait_r;
  assign AV_READDATA = rdata_r;
  assign DIO_O = dio_o_r;
  assign DIO_OE = {8{dio_oe_r}};
  assign DAV_O = dav_o_r;
  assign DAV_OE = dav_oe_r;
  assign NRFD_O = nrfd_o_r;
  assign NRFD_OE = nrfd_oe_r;
  assign NDAC_O = ndac_o_r;
  assign NDAC_OE = ndac_oe_r;
  assign ATN_O = atn_o_r;
  assign ATN_OE = atn_oe_r;
  assign IFC_O = ifc_o_r;
  assign IFC_OE = ifc_oe_r;
  assign REN_O = ren_o_r;
  assign REN_OE = ren_oe_r;
  assign EOI_DAV_CTL = sense_ctl;
  assign DATA_OUT_DIR = acc_mode_r;
endmodule
`default_nettype wire

// file: gpc_pkg.sv
// Shared constants and types of the bus controller command block
package gpc_pkg;

  // ********************************************************
  // Clock and timing
  // ********************************************************
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int US_W = 11;
  localparam int IFC_PULSE_US = 100;
  localparam int TAKE_DAV_US = 100;
  localparam int READY_WAIT_US = 100;
  localparam int ACCEPT_WAIT_US = 1000;
  localparam int SENSE_CYC = 2;

  // ********************************************************
  // Register map, byte addresses
  // ********************************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PINS = 4'h8;

  // ********************************************************
  // Command word fields
  // ********************************************************
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int CMD_PRM_LSB = 8;
  localparam int PRM_IFC = 0;
  localparam int PRM_REN = 1;
  localparam int PRM_REN_UPD = 2;
  localparam int PRM_ASYNC = 0;

  // ********************************************************
  // Status word fields and result bits
  // ********************************************************
  localparam int ST_BUSY = 8;
  localparam int ST_ACC_MODE = 9;
  localparam int ST_ATN_ON = 10;
  localparam int RES_NO_LISTENER = 0;
  localparam int RES_READY_TO = 1;
  localparam int RES_ACCEPT_TO = 2;
  localparam int RES_ANY_ERR = 7;
  localparam int RES_SRQ = 0;
  localparam logic [7:0] RESULT_RST = 8'h00;

  typedef enum logic [2:0] {
    OP_CONTROL_OUT,
    OP_STATUS_IN,
    OP_STANDBY,
    OP_TAKE_CONTROL,
    OP_IFACE_MSG,
    OP_ACCEPT_MODE
  } gpc_op_t;

  typedef enum {
    S_IDLE,
    S_IFC,
    S_SRQ,
    S_TAKE,
    S_NRFD,
    S_NDAC,
    S_FIN
  } gpc_state_t;

  function automatic logic [7:0] gpc_err(input int pos);
    logic [7:0] v;
    v = 8'h00;
    v[pos] = 1'b1;
    v[RES_ANY_ERR] = 1'b1;
    return v;
  endfunction

endpackage

// file: gpc_us_timer.sv
// Microsecond timeout counter built from a cycle prescaler
`timescale 1ns/100ps
`default_nettype none
module gpc_us_timer #(
  parameter int CYC_PER_US = 50,
  parameter int US_W = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [US_W-1:0] limit_us,
  output logic expired
);
  localparam int CW = $clog2(CYC_PER_US + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_US - 1);

  logic [CW-1:0] cyc_r;
  logic [US_W-1:0] us_r;
  logic wrap;

  assign wrap = (cyc_r == CYC_LAST);
  assign expired = (us_r >= limit_us);

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cyc_r <= '0;
      us_r <= '0;
    end else if (!expired) begin
      cyc_r <= wrap ? '0 : cyc_r + CW'(1);
      us_r <= wrap ? us_r + US_W'(1) : us_r;
    end
  end
endmodule
`default_nettype wire

// file: gpc_srq_sense.sv
// Service request sensing through an edge-only path
`timescale 1ns/100ps
`default_nettype none
module gpc_srq_sense #(
  parameter int SENSE_CYC = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic en_i,
  input wire logic srq_n_i,
  output logic ctl_o,
  output logic done,
  output logic seen
);
  localparam int CW = $clog2(SENSE_CYC + 1);

  logic [CW-1:0] cnt_r;
  logic act_r;
  logic comb_d_r;
  logic comb;
  logic edge_hit;

  // Edge path only: a level never shows unless the control line moves
  assign comb = ~srq_n_i & ~ctl_o;
  assign edge_hit = comb & ~comb_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      act_r <= 1'b0;
      ctl_o <= 1'b0;
      comb_d_r <= 1'b0;
      done <= 1'b0;
      seen <= 1'b0;
    end else begin
      comb_d_r <= comb;
      done <= 1'b0;
      if (start) begin
        act_r <= 1'b1;
        cnt_r <= CW'(SENSE_CYC);
        ctl_o <= 1'b0;
        seen <= 1'b0;
      end else if (act_r) begin
        seen <= seen | edge_hit;
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == '0) begin
          act_r <= 1'b0;
          done <= 1'b1;
          ctl_o <= en_i;
        end
      end else begin
        ctl_o <= en_i;
      end
    end
  end
endmodule
`default_nettype wire

// file: gpc_controller_sva.sv
// Assertion checker for the bus controller command block
`timescale 1ns/100ps
`default_nettype none
module gpc_controller_sva #(
  parameter int CLK_PER_US = 50,
  parameter int IFC_US = 100
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic AV_WAITREQUEST,
  input wire logic [7:0] DIO_OE,
  input wire logic DAV_O,
  input wire logic DAV_OE,
  input wire logic NRFD_I,
  input wire logic NDAC_I,
  input wire logic ATN_O,
  input wire logic ATN_OE,
  input wire logic IFC_O,
  input wire logic IFC_OE,
  input wire logic REN_OE,
  input wire logic EOI_DAV_CTL,
  input wire logic DATA_OUT_DIR
);
  // *****
  // Clear pulse length
  // *****
  localparam int IFC_N = CLK_PER_US * IFC_US;
  wire logic ifc_act;
  logic [15:0] ifc_cnt_r;
  logic [15:0] ifc_cnt_nxt;
  assign ifc_act = IFC_OE && !IFC_O;
  assign ifc_cnt_nxt = ifc_act ? ifc_cnt_r + 16'h0001 : 16'h0000;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ifc_cnt_r <= 16'h0000;
    end else begin
      ifc_cnt_r <= ifc_cnt_nxt;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // *****
  // Properties
  // *****
  AST_RST_IDLE: assert property ($past(RST) |->
    !ATN_OE && !IFC_OE && !REN_OE && !DAV_OE && DIO_OE == 8'h00 && !EOI_DAV_CTL)
    else $error("pins driven after reset");
  AST_ACK: assert property ($rose(AV_READ || AV_WRITE) |=> !AV_WAITREQUEST)
    else $error("bus access not answered");
  AST_ACK_ONE: assert property (!AV_WAITREQUEST |=> AV_WAITREQUEST)
    else $error("answer longer than one cycle");
  AST_IFC_LEN: assert property ($fell(ifc_act) |->
    ifc_cnt_r >= IFC_N - 1 && ifc_cnt_r <= IFC_N + 1)
    else $error("clear pulse length wrong");
  AST_IFC_ATN: assert property (ifc_act |-> ATN_OE && ATN_O)
    else $error("attention not high during clear");
  AST_SENSE: assert property ($fell(EOI_DAV_CTL) && !DATA_OUT_DIR |->
    !EOI_DAV_CTL [*3] ##1 EOI_DAV_CTL)
    else $error("sense drop length wrong");
  AST_DAV_SET: assert property ($fell(DAV_O) && DAV_OE |->
    $past(NRFD_I) && !$past(NDAC_I))
    else $error("data valid without ready listener");
  AST_DAV_REL: assert property ($rose(DAV_O) && DAV_OE |->
    $past(NDAC_I) && DIO_OE == 8'h00)
    else $error("data valid release wrong");
  AST_MSG_ATN: assert property (DAV_OE && !DAV_O |->
    ATN_OE && !ATN_O && DIO_OE == 8'hFF)
    else $error("message sent without attention");
  AST_ACC_MODE: assert property (DATA_OUT_DIR |-> !EOI_DAV_CTL && DIO_OE == 8'h00)
    else $error("acceptor mode still sourcing");
endmodule
bind gpc_controller gpc_controller_sva #(.CLK_PER_US(CLK_PER_US), .IFC_US(IFC_US)) chk_u (
  .CLK(CLK), .RST(RST), .AV_READ(AV_READ), .AV_WRITE(AV_WRITE),
  .AV_WAITREQUEST(AV_WAITREQUEST), .DIO_OE(DIO_OE), .DAV_O(DAV_O), .DAV_OE(DAV_OE),
  .NRFD_I(NRFD_I), .NDAC_I(NDAC_I), .ATN_O(ATN_O), .ATN_OE(ATN_OE), .IFC_O(IFC_O),
  .IFC_OE(IFC_OE), .REN_OE(REN_OE), .EOI_DAV_CTL(EOI_DAV_CTL), .DATA_OUT_DIR(DATA_OUT_DIR));
`default_nettype wire

// file: gpc_bus_partner.sv
// Listener and talker model on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module gpc_bus_partner (
  input wire logic clk,
  input wire logic [2:0] mode,
  input wire logic dav_l,
  input wire logic [7:0] dio_l,
  output logic nrfd_pull,
  output logic ndac_pull,
  output logic dav_pull,
  output logic [7:0] got
);
  // Modes: 0 prompt, 5 slow, 1 absent, 2 never ready, 3 never accepts, 4 talker stuck
  logic [3:0] hold_r;
  initial begin
    nrfd_pull = 1'b0;
    ndac_pull = 1'b1;
    dav_pull = 1'b0;
    got = 8'h00;
    hold_r = 4'h0;
  end
  always @(posedge clk) begin
    dav_pull <= (mode == 3'h4);
    if (mode == 3'h1) begin
      nrfd_pull <= 1'b0;
      ndac_pull <= 1'b0;
    end else if (mode == 3'h2) begin
      nrfd_pull <= 1'b1;
      ndac_pull <= 1'b1;
    end else if (!dav_l) begin
      if (hold_r == 4'h0) got <= ~dio_l;
      if (hold_r != 4'hF) hold_r <= hold_r + 4'h1;
      nrfd_pull <= 1'b1;
      ndac_pull <= (mode == 3'h3) || (mode == 3'h5 && hold_r < 4'h6);
    end else begin
      hold_r <= 4'h0;
      nrfd_pull <= 1'b0;
      ndac_pull <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: gpib_controller_commands_tb_top.sv
// Self-checking bench for the bus controller command block
`timescale 1ns/100ps
`default_nettype none
module gpib_controller_commands_tb_top;
  // *****
  // Wiring
  // *****
  localparam int CPU = 1;
  localparam int IFCN = 5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [3:0] av_addr = 4'h0;
  logic [31:0] av_wdata = 32'h0;
  logic srq_l = 1'b1;
  logic [2:0] pmode = 3'h0;
  logic [31:0] av_rdata;
  logic av_wait, dav_o, dav_oe, nrfd_o, nrfd_oe, ndac_o, ndac_oe, p_nrfd, p_ndac, p_dav;
  logic atn_o, atn_oe, ifc_o, ifc_oe, ren_o, ren_oe, eoi_ctl, out_dir, ren_e;
  logic [7:0] dio_o, dio_oe, p_got, b, eb;
  logic [31:0] rq;
  wire logic [7:0] dio_l;
  wire logic dav_l, nrfd_l, ndac_l;
  int num_errors = 0;
  int n_tests = 0;
  int ifc_cnt = 0;
  int exp_q[$];
  int mt[6] = '{0, 5, 2, 3, 0, 1};
  logic [7:0] ren_tab[4] = '{8'h04, 8'h06, 8'h00, 8'h02};
  always #10 clk = ~clk;
  assign dio_l = ~(dio_oe & ~dio_o);
  assign dav_l = ~(dav_oe & ~dav_o) & ~p_dav;
  assign nrfd_l = ~(nrfd_oe & ~nrfd_o) & ~p_nrfd;
  assign ndac_l = ~(ndac_oe & ~ndac_o) & ~p_ndac;
  always @(posedge clk) if (ifc_oe === 1'b1 && ifc_o === 1'b0) ifc_cnt++;
  gpc_controller #(.CLK_PER_US(CPU), .IFC_US(IFCN), .TAKE_US(5), .READY_US(5),
    .ACCEPT_US(20)) dut_u (
    .CLK(clk), .RST(rst), .AV_ADDRESS(av_addr), .AV_READ(av_rd), .AV_WRITE(av_wr),
    .AV_WRITEDATA(av_wdata), .AV_BYTEENABLE(4'hF), .AV_READDATA(av_rdata),
    .AV_WAITREQUEST(av_wait), .DIO_I(dio_l), .DIO_O(dio_o), .DIO_OE(dio_oe),
    .DAV_I(dav_l), .DAV_O(dav_o), .DAV_OE(dav_oe), .NRFD_I(nrfd_l), .NRFD_O(nrfd_o),
    .NRFD_OE(nrfd_oe), .NDAC_I(ndac_l), .NDAC_O(ndac_o), .NDAC_OE(ndac_oe),
    .ATN_O(atn_o), .ATN_OE(atn_oe), .IFC_O(ifc_o), .IFC_OE(ifc_oe), .REN_O(ren_o),
    .REN_OE(ren_oe), .SRQ_I(srq_l), .EOI_DAV_CTL(eoi_ctl), .DATA_OUT_DIR(out_dir));
  gpc_bus_partner p_u (.clk(clk), .mode(pmode), .dav_l(dav_l), .dio_l(dio_l),
    .nrfd_pull(p_nrfd), .ndac_pull(p_ndac), .dav_pull(p_dav), .got(p_got));
  // *****
  // Tasks and model
  // *****
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    av_wr <= wr;
    av_rd <= !wr;
    av_addr <= a;
    av_wdata <= d;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  function automatic int model(input int op, input int prm);
    if (op > 5) return 32'h80;
    if (op == 1) return srq_l ? 0 : 1;
    if (op == 3) return (prm == 0 && pmode == 3'h4) ? 32'h84 : 0;
    if (op != 4 || pmode == 3'h0 || pmode == 3'h5) return 0;
    return 32'h80 | (1 << (pmode - 1));
  endfunction
  task automatic run(input gpc_pkg::gpc_op_t op, input logic [7:0] p);
    logic [31:0] q;
    exp_q.push_back(model(int'(op), int'(p)));
    bus(1'b1, gpc_pkg::REG_CMD, {16'h0, p, 5'h00, op}, q);
    do begin
      bus(1'b0, gpc_pkg::REG_STATUS, 32'h0, q);
    end while (q[gpc_pkg::ST_BUSY] !== 1'b0);
    chk({24'h0, q[7:0]}, exp_q.pop_front());
  endtask
  // *****
  // Scenarios
  // *****
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
  initial begin
    b = 8'($urandom(37080));
    ren_e = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({ifc_oe, atn_oe, ren_oe, dav_oe, eoi_ctl, out_dir, dio_oe}, 32'h0);
    bus(1'b0, 4'hC, 32'h0, rq);
    chk(rq, 32'h0);
    bus(1'b0, gpc_pkg::REG_PINS, 32'h0, rq);
    chk(rq, 32'h000016FF);
    for (int i = 0; i < 4; i++) begin
      if (ren_tab[i][2]) ren_e = !ren_tab[i][1];
      run(gpc_pkg::OP_CONTROL_OUT, ren_tab[i]);
      chk({ren_oe, ren_o}, {1'b1, ren_e});
    end
    run(gpc_pkg::OP_CONTROL_OUT, 8'h01);
    chk(ifc_cnt >= CPU * IFCN - 1 && ifc_cnt <= CPU * IFCN + 1, 1);
    chk({ren_oe, ren_o, atn_oe, atn_o}, {1'b1, ren_e, 2'b11});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      srq_l <= i[0];
      @(posedge clk);
      run(gpc_pkg::OP_STATUS_IN, 8'h00);
    end
    run(gpc_pkg::OP_ACCEPT_MODE, 8'h00);
    chk({out_dir, nrfd_oe, nrfd_o, ndac_oe, ndac_o}, 5'b11010);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      pmode <= mt[i][2:0];
      b = 8'($urandom);
      @(posedge clk);
      run(gpc_pkg::OP_IFACE_MSG, b);
      chk({out_dir, atn_oe, atn_o, nrfd_oe, ndac_oe}, 5'b01000);
      if (mt[i] != 1 && mt[i] != 2 && (i == 0 || mt[i - 1] != 3)) eb = b;
      if (mt[i] != 1 && mt[i] != 2) chk(p_got, eb);
      if (mt[i] == 3) chk({dav_oe, dav_o, dio_oe}, 10'h2FF);
      if (mt[i] == 1) chk(dio_oe, 8'hFF);
    end
    for (int i = 0; i < 3; i++) begin
      run(gpc_pkg::OP_STANDBY, 8'h00);
      chk({atn_oe, dio_oe}, 9'h000);
      @(posedge clk);
      pmode <= (i == 1) ? 3'h0 : 3'h4;
      @(posedge clk);
      run(gpc_pkg::OP_TAKE_CONTROL, (i == 2) ? 8'h01 : 8'h00);
      chk({atn_oe, atn_o}, (i == 0) ? 2'b01 : 2'b10);
    end
    run(gpc_pkg::gpc_op_t'(3'h6), 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
